// ==== hw/debug_timeout_pkg.sv ====
// shared constants and types for the single-wire debug link time-out logic
// How it works
// R1 - handshake on: no time-out awaiting handshake
// R2 - handshake pulse re-arms 512-cycle time-out
// R3 - host retrieves data within 512 cycles
// R4 - expiry drops read, data gone
// R5 - after expiry, falling edge starts command
// R6 - partial transfer stalls 512+ cycles: soft-reset
// R7 - after soft-reset, edge starts new command
// R8 - gap counter restarts on edges, gated
package debug_timeout_pkg;

    // serial clock equals i_clk here; raise the divider if it runs slower
    localparam int TIMEOUT_SERIAL_CYCLES = 512;
    localparam int SERIAL_CLK_DIV        = 1;
    localparam int TIMEOUT_CYCLES        = TIMEOUT_SERIAL_CYCLES * SERIAL_CLK_DIV;
    localparam int TIMER_W               = $clog2(TIMEOUT_CYCLES + 1);

    // reset values
    localparam logic PIN_RESET   = 1'b1;
    localparam logic PULSE_RESET = 1'b0;
    localparam logic VALID_RESET = 1'b0;

    // gray coded along idle -> active -> wait -> ack
    typedef enum logic [1:0] {
        S_IDLE   = 2'b00,
        S_ACTIVE = 2'b01,
        S_WAIT   = 2'b11,
        S_ACK    = 2'b10
    } link_state_t;

    // receiver events, one-cycle pulses
    typedef struct packed {
        logic read_issued;
        logic ack_pulse;
        logic transfer_done;
    } link_events_t;

endpackage

// ==== hw/gap_timer.sv ====
// saturating gap counter that restarts on request
`timescale 1ns/1ps
module gap_timer #(
    parameter int               WIDTH = 10,
    parameter logic [WIDTH-1:0] LIMIT = 10'h200
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    // control
    input  wire logic             i_restart,
    input  wire logic             i_enable,
    // status
    output logic [WIDTH-1:0]      o_count,
    output logic                  o_expired
);

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    always_comb begin
        next_count = count;
        if (i_restart) begin
            next_count = '0;
        end else if (i_enable && count != LIMIT) begin
            next_count = count + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign o_count   = count;
    // count sitting at the limit with no restart in that cycle means the gap exceeded it
    assign o_expired = i_enable && (count == LIMIT) && !i_restart;

endmodule

// ==== hw/debug_serial_timeout.sv ====
// time-out supervision of the single-wire debug link receiver
`timescale 1ns/1ps
module debug_serial_timeout #(
    parameter int TIMEOUT = debug_timeout_pkg::TIMEOUT_CYCLES
) (
    // clock and reset
    input  wire logic                            i_clk,
    input  wire logic                            i_rst,
    // single wire debug pin, sampled level
    input  wire logic                            i_single_wire_debug_pin,
    // receiver side
    input  wire logic                            i_ack_enable,
    input  wire debug_timeout_pkg::link_events_t i_events,
    // supervision results
    output logic                                 o_new_cmd_start,
    output logic                                 o_soft_reset,
    output logic                                 o_read_discard,
    output logic                                 o_data_valid,
    output debug_timeout_pkg::link_state_t       o_state
);

    localparam int TW = debug_timeout_pkg::TIMER_W;
    localparam logic [TW-1:0] LIMIT = TW'(TIMEOUT);

    debug_timeout_pkg::link_state_t state;
    debug_timeout_pkg::link_state_t next_state;
    logic          pin_q;
    logic          next_pin_q;
    logic          new_cmd_start;
    logic          next_new_cmd_start;
    logic          soft_reset;
    logic          next_soft_reset;
    logic          read_discard;
    logic          next_read_discard;
    logic          data_valid;
    logic          next_data_valid;
    logic          fall;
    logic          timer_restart;
    logic          timer_enable;
    logic          expired;
    logic [TW-1:0] gap_count;

    // pin is synchronous already, so a single history flop suffices
    assign fall = pin_q && !i_single_wire_debug_pin;

    // waiting for the handshake is unsupervised; ack re-arms the timer
    assign timer_enable  = (state == debug_timeout_pkg::S_ACTIVE) ||
                           (state == debug_timeout_pkg::S_ACK); // [R1] [R8]
    assign timer_restart = fall || i_events.ack_pulse; // [R2] [R8]

    gap_timer #(
        .WIDTH     (TW),
        .LIMIT     (LIMIT)
    ) u_gap_timer (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_restart (timer_restart),
        .i_enable  (timer_enable),
        .o_count   (gap_count),
        .o_expired (expired)
    );

    always_comb begin
        next_state         = state;
        next_pin_q         = i_single_wire_debug_pin;
        next_new_cmd_start = 1'b0;
        next_soft_reset    = 1'b0;
        next_read_discard  = 1'b0;
        next_data_valid    = data_valid;
        case (state)
            debug_timeout_pkg::S_IDLE: begin
                // only a falling edge of the pin here opens a new command
                if (fall) begin
                    next_state         = debug_timeout_pkg::S_ACTIVE; // [R5] [R7]
                    next_new_cmd_start = 1'b1;
                end
            end
            debug_timeout_pkg::S_ACTIVE: begin
                if (expired) begin
                    next_state      = debug_timeout_pkg::S_IDLE; // [R6]
                    next_soft_reset = 1'b1;
                    next_data_valid = 1'b0;
                end else if (i_events.read_issued && i_ack_enable) begin
                    next_state      = debug_timeout_pkg::S_WAIT; // [R1]
                    next_data_valid = 1'b1;
                end else if (i_events.read_issued) begin
                    // without handshake the read stays under supervision
                    next_data_valid = 1'b1;
                end else if (i_events.transfer_done) begin
                    next_state      = debug_timeout_pkg::S_IDLE;
                    next_data_valid = 1'b0;
                end
            end
            debug_timeout_pkg::S_WAIT: begin
                // host may linger here for any number of cycles
                if (i_events.ack_pulse) begin
                    next_state = debug_timeout_pkg::S_ACK; // [R2]
                end
            end
            debug_timeout_pkg::S_ACK: begin
                if (expired) begin
                    next_state        = debug_timeout_pkg::S_IDLE; // [R4]
                    next_read_discard = 1'b1;
                    next_data_valid   = 1'b0;
                end else if (fall) begin
                    // retrieval started, now a partial data transfer
                    next_state = debug_timeout_pkg::S_ACTIVE;
                end
            end
            default: begin
                next_state = debug_timeout_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state         <= debug_timeout_pkg::S_IDLE;
            pin_q         <= debug_timeout_pkg::PIN_RESET;
            new_cmd_start <= debug_timeout_pkg::PULSE_RESET;
            soft_reset    <= debug_timeout_pkg::PULSE_RESET;
            read_discard  <= debug_timeout_pkg::PULSE_RESET;
            data_valid    <= debug_timeout_pkg::VALID_RESET;
        end else begin
            state         <= next_state;
            pin_q         <= next_pin_q;
            new_cmd_start <= next_new_cmd_start;
            soft_reset    <= next_soft_reset;
            read_discard  <= next_read_discard;
            data_valid    <= next_data_valid;
        end
    end

    assign o_new_cmd_start = new_cmd_start;
    assign o_soft_reset    = soft_reset;
    assign o_read_discard  = read_discard;
    assign o_data_valid    = data_valid;
    assign o_state         = state;

    // the timer only expires exactly at its limit
    chk_expire_limit: assert property (@(posedge i_clk) disable iff (i_rst) // [R6]
        expired |-> (gap_count == LIMIT) && (state != debug_timeout_pkg::S_WAIT))
        else $error("timer expired off its limit");

    chk_wait_untimed: assert property (@(posedge i_clk) disable iff (i_rst) // [R1]
        (state == debug_timeout_pkg::S_WAIT && !i_events.ack_pulse)
        |=> (state == debug_timeout_pkg::S_WAIT) && !o_read_discard && !o_soft_reset)
        else $error("time-out applied while awaiting handshake");

    chk_ack_rearm: assert property (@(posedge i_clk) disable iff (i_rst) // [R2]
        (state == debug_timeout_pkg::S_WAIT && i_events.ack_pulse)
        |=> (state == debug_timeout_pkg::S_ACK) && (gap_count == '0) ##1 (gap_count == 1))
        else $error("handshake did not re-arm the timer");

    chk_ack_expiry: assert property (@(posedge i_clk) disable iff (i_rst) // [R4]
        (state == debug_timeout_pkg::S_ACK && expired)
        |=> o_read_discard && !o_data_valid && (state == debug_timeout_pkg::S_IDLE)
        ##1 !o_read_discard)
        else $error("expired read not discarded");

    chk_idle_edge: assert property (@(posedge i_clk) disable iff (i_rst) // [R5]
        (state == debug_timeout_pkg::S_IDLE && fall)
        |=> o_new_cmd_start && (state == debug_timeout_pkg::S_ACTIVE) && (gap_count == '0))
        else $error("edge after expiry not taken as new command");

    chk_stall_reset: assert property (@(posedge i_clk) disable iff (i_rst) // [R6]
        (state == debug_timeout_pkg::S_ACTIVE && expired)
        |=> o_soft_reset && !o_data_valid && (state == debug_timeout_pkg::S_IDLE))
        else $error("stalled transfer not soft-reset");

    chk_reset_idle: assert property (@(posedge i_clk) disable iff (i_rst) // [R7]
        $rose(o_soft_reset) |-> (state == debug_timeout_pkg::S_IDLE) && !$past(fall))
        else $error("soft-reset did not return to idle");

    chk_count_restart: assert property (@(posedge i_clk) disable iff (i_rst) // [R8]
        fall |=> (gap_count == '0))
        else $error("falling edge did not restart gap counter");

    chk_count_gated: assert property (@(posedge i_clk) disable iff (i_rst) // [R8]
        (!timer_enable && !timer_restart) |=> $stable(gap_count))
        else $error("gap counter ran while not supervising");

    // supervised gaps must advance one serial cycle per clock
    chk_count_step: assert property (@(posedge i_clk) disable iff (i_rst) // [R8]
        (timer_enable && !timer_restart && gap_count != LIMIT)
        |=> (gap_count == $past(gap_count) + 1'b1))
        else $error("gap counter did not advance");

    chk_count_bound: assert property (@(posedge i_clk) disable iff (i_rst) // [R8]
        gap_count <= LIMIT)
        else $error("gap counter ran past its limit");

    // pending read must stay available however long the host waits
    chk_wait_valid: assert property (@(posedge i_clk) disable iff (i_rst) // [R1]
        (state == debug_timeout_pkg::S_WAIT) |-> o_data_valid)
        else $error("read data lost while awaiting handshake");

    chk_discard_source: assert property (@(posedge i_clk) disable iff (i_rst) // [R4]
        o_read_discard |-> ($past(state) == debug_timeout_pkg::S_ACK))
        else $error("read discarded outside post-handshake window");

    chk_soft_source: assert property (@(posedge i_clk) disable iff (i_rst) // [R6]
        o_soft_reset |-> ($past(state) == debug_timeout_pkg::S_ACTIVE))
        else $error("soft-reset outside a partial transfer");

    // a receiver restart and a new command never overlap
    chk_pulse_exclusive: assert property (@(posedge i_clk) disable iff (i_rst) // [R7]
        $onehot0({o_new_cmd_start, o_soft_reset, o_read_discard}))
        else $error("supervision pulses overlap");

    cov_stall: cover property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_soft_reset));
    cov_discard: cover property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_read_discard));
    cov_retrieve: cover property (@(posedge i_clk) disable iff (i_rst)
        (state == debug_timeout_pkg::S_ACK) && fall);
    cov_long_wait: cover property (@(posedge i_clk) disable iff (i_rst)
        (state == debug_timeout_pkg::S_WAIT) [*8] ##1 i_events.ack_pulse);
    // read without handshake stays under the gap timer
    cov_plain_read: cover property (@(posedge i_clk) disable iff (i_rst)
        (state == debug_timeout_pkg::S_ACTIVE) && i_events.read_issued && !i_ack_enable);

endmodule

// ==== sim/debug_host_model.sv ====
// behavioural debug host that drives the single-wire pin
`timescale 1ns/1ps
module debug_host_model #(
    parameter int TIMEOUT = 8
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // requests from the bench
    input  wire logic i_fall,
    input  wire logic i_ack,
    input  wire logic i_late,
    // driven pin level
    output logic      o_pin
);
    int   wait_cnt;
    logic armed;
    // pull-up on the pin: released between pulses it reads high
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pin    <= 1'b1;
            armed    <= 1'b0;
            wait_cnt <= 0;
        end else if (i_ack) begin
            o_pin    <= ~i_fall;
            armed    <= 1'b1;
            wait_cnt <= 0;
        end else if (armed && wait_cnt == (i_late ? TIMEOUT + 3 : TIMEOUT / 2)) begin
            o_pin    <= 1'b0;
            armed    <= 1'b0;
            wait_cnt <= wait_cnt + 1;
        end else begin
            o_pin    <= ~i_fall;
            wait_cnt <= wait_cnt + 1;
        end
    end
endmodule

// ==== sim/tb_debug_serial_timeout.sv ====
// self-checking bench for the debug link time-out supervisor
`timescale 1ns/1ps
module tb_debug_serial_timeout;
    localparam int T = 8;
    logic                            i_clk = 1'b0;
    logic                            i_rst = 1'b1;
    logic                            debug_pin;
    logic                            ack_en = 1'b0;
    logic                            fall_req = 1'b0;
    logic                            late = 1'b0;
    debug_timeout_pkg::link_events_t ev = '0;
    logic                            new_cmd, soft_rst, discard, dv;
    debug_timeout_pkg::link_state_t  st;
    debug_timeout_pkg::link_state_t  e_st = debug_timeout_pkg::S_IDLE;
    logic [2:0]                      e_pulse = 3'h0;
    logic                            e_dv = 1'b0;
    logic                            e_prev = 1'b1;
    int                              cnt, n_fail, compares;

    initial forever #5 i_clk = ~i_clk;

    debug_host_model #(.TIMEOUT(T)) i_debug_host_model (.i_clk(i_clk), .i_rst(i_rst),
        .i_fall(fall_req), .i_ack(ev.ack_pulse), .i_late(late), .o_pin(debug_pin));

    debug_serial_timeout #(.TIMEOUT(T)) i_debug_serial_timeout (.i_clk(i_clk), .i_rst(i_rst),
        .i_single_wire_debug_pin(debug_pin), .i_ack_enable(ack_en), .i_events(ev),
        .o_new_cmd_start(new_cmd), .o_soft_reset(soft_rst), .o_read_discard(discard),
        .o_data_valid(dv), .o_state(st));

    // reference model, reads inputs before this edge's updates land
    always @(posedge i_clk) begin
        logic fall, restart, expd, run;
        fall = e_prev & ~debug_pin;
        restart = fall | ev.ack_pulse;
        run = (e_st == debug_timeout_pkg::S_ACTIVE) || (e_st == debug_timeout_pkg::S_ACK);
        expd = run && cnt == T && !restart;
        e_pulse = 3'h0;
        e_prev = debug_pin;
        if (restart) cnt = 0;
        else if (run && cnt < T) cnt++;
        if (i_rst) begin
            cnt = 0;
            e_prev = 1'b1;
            e_st = debug_timeout_pkg::S_IDLE;
            e_dv = 1'b0;
        end else if (e_st == debug_timeout_pkg::S_IDLE && fall) begin
            e_st = debug_timeout_pkg::S_ACTIVE;
            e_pulse[2] = 1'b1;
        end else if (expd) begin
            e_pulse = (e_st == debug_timeout_pkg::S_ACTIVE) ? 3'h2 : 3'h1;
            e_st = debug_timeout_pkg::S_IDLE;
            e_dv = 1'b0;
        end else if (e_st == debug_timeout_pkg::S_ACTIVE && ev.read_issued) begin
            e_dv = 1'b1;
            if (ack_en) e_st = debug_timeout_pkg::S_WAIT;
        end else if (e_st == debug_timeout_pkg::S_ACTIVE && ev.transfer_done) begin
            e_st = debug_timeout_pkg::S_IDLE;
            e_dv = 1'b0;
        end else if (e_st == debug_timeout_pkg::S_WAIT && ev.ack_pulse) begin
            e_st = debug_timeout_pkg::S_ACK;
        end else if (e_st == debug_timeout_pkg::S_ACK && fall) begin
            e_st = debug_timeout_pkg::S_ACTIVE;
        end
    end

    task automatic chk_pulse(input logic [2:0] got, input logic [2:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: pulses %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chk_level(input logic [2:0] got, input logic [2:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: valid/state %b expected %b", $time, got, exp);
        end
    endtask

    always @(negedge i_clk) begin
        chk_pulse({new_cmd, soft_rst, discard}, e_pulse);
        chk_level({dv, st}, {e_dv, e_st});
    end

    task automatic give_verdict;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // k: 0 pin fall, 1 read, 2 ack pulse, 3 transfer done
    task automatic act(input int k, input int gap);
        @(posedge i_clk);
        fall_req <= (k == 0);
        ev <= '{read_issued: (k == 1), ack_pulse: (k == 2), transfer_done: (k == 3)};
        @(posedge i_clk);
        fall_req <= 1'b0;
        ev <= '0;
        repeat (gap) @(posedge i_clk);
    endtask

    initial begin
        repeat (40000) @(posedge i_clk);
        n_fail++;
        $display("mismatch at %0t: run did not finish", $time);
        give_verdict();
    end

    initial begin
        void'($urandom(32'hb638));
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        ack_en <= 1'b1;
        late <= 1'b1;
        act(0, 2);
        act(1, 3 * T);
        act(2, 2 * T);
        act(0, T + 4);
        act(0, 2);
        i_rst <= 1'b1;
        act(0, 2);
        i_rst <= 1'b0;
        for (int i = 0; i < 1500; i++) begin
            ack_en <= 1'($urandom % 2);
            late <= 1'($urandom % 2);
            act($urandom % 4, $urandom % (T + 4));
        end
        give_verdict();
    end
endmodule
